// >>> pkg/task_switch_params.svh
// Constants for the task-switch control block
`ifndef TASK_SWITCH_PARAMS_SVH
`define TASK_SWITCH_PARAMS_SVH

// Register port offsets (word index)
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h1
`define REG_TASK 4'h2

// Control register fields
`define CTRL_LONG_MODE 0
`define CTRL_CLEAR_SWITCHED 1

// Status register fields
`define STAT_LEVEL_LSB 0
`define STAT_NESTED 2
`define STAT_SWITCHED 3
`define STAT_PENDING 4
`define STAT_ACTIVE 5

// Smallest legal task state segment limit (67h, 104 bytes)
`define STATE_SEG_MIN_LIMIT 32'h00000067

// Busy indication position inside the descriptor
`define BUSY_BYTE_OFFSET 4'h4
`define BUSY_BIT_INDEX 4'h9

// Nested flag value written for call-like entries
`define NESTED_SET 1'b1

`endif

// >>> pkg/task_switch_pkg.sv
// Types shared by the task-switch control block
package task_switch_pkg;

   typedef enum logic [4:0] {
      CAUSE_JUMP = 5'h01,
      CAUSE_CALL = 5'h02,
      CAUSE_SOFT_INT = 5'h04,
      CAUSE_EXTERNAL = 5'h08,
      CAUSE_INT_RETURN = 5'h10
   } cause_e;

   typedef enum logic [2:0] {
      TABLE_GLOBAL = 3'h1,
      TABLE_LOCAL = 3'h2,
      TABLE_INTERRUPT = 3'h4
   } table_e;

   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_CHECK = 10'h002,
      ST_SAVE = 10'h004,
      ST_TASK_LOAD = 10'h008,
      ST_BUSY = 10'h010,
      ST_FLAG_SET = 10'h020,
      ST_LOAD = 10'h040,
      ST_MAP_LOAD = 10'h080,
      ST_DESC_LOAD = 10'h100,
      ST_DONE = 10'h200
   } state_e;

   // One switch request as decoded by the front end
   typedef struct packed {
      cause_e cause;
      logic viaGate;
      table_e gateTable;
      logic [1:0] requestedLevel;
      logic [1:0] gateLevel;
      logic [1:0] descriptorLevel;
      logic [31:0] segLimit;
      logic targetBusy;
      logic [15:0] targetSel;
      logic [15:0] linkSel;
   } switch_req_s;

   // Step command to the state-moving machinery
   typedef struct packed {
      logic save;
      logic saveNested;
      logic taskLoad;
      logic busyUpdate;
      logic oldBusyWrite;
      logic oldBusyValue;
      logic newBusyWrite;
      logic newBusyValue;
      logic flagSet;
      logic load;
      logic presentClear;
      logic linkWrite;
      logic [15:0] linkSel;
      logic mapLoad;
      logic descLoad;
      logic [15:0] targetSel;
   } step_s;

endpackage : task_switch_pkg

// >>> hdl/task_switch_control.sv
// Hardware task-switch sequencer with checks, nesting and busy handling
`timescale 1ns/1ns
`default_nettype none
`include "task_switch_params.svh"

module task_switch_control
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Switch request
   input wire logic reqValid,
   input wire task_switch_pkg::switch_req_s req,
   // Step handshake
   input wire logic stepDone,
   input wire logic stepFault,
   input wire logic [15:0] loadCodeSel,
   input wire logic loadNested,
   // Media instruction attempt
   input wire logic mediaAttempt,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   // Step command and results
   output task_switch_pkg::step_s step,
   output logic protectionFault,
   output logic invalidStateFault,
   output logic deviceUnavailableFault,
   output logic resume,
   output logic switchActive,
   output logic [15:0] taskRegister,
   output logic [1:0] currentPrivilegeLevel,
   output logic nestedTaskFlag,
   output logic taskSwitchedFlag,
   output logic longMode
);
   import task_switch_pkg::*;

   // ----------------------------------------------------------------
   // Request capture and checks
   // ----------------------------------------------------------------
   state_e state;
   state_e next_state;
   switch_req_s cur;
   logic [15:0] oldSel;
   logic pendingLate;
   logic isJump;
   logic callLike;
   logic isReturn;
   logic protRefuse;
   logic limitRefuse;
   logic startReq;
   logic [1:0] codeLevel;
   step_s next_step;

   assign codeLevel = loadCodeSel[1:0];
   assign isJump = (cur.cause == CAUSE_JUMP);
   assign isReturn = (cur.cause == CAUSE_INT_RETURN);
   assign callLike = !isJump && !isReturn;
   // Plain interrupt return is not ours and is dropped here
   assign startReq = reqValid && (state == ST_IDLE) &&
                     ((req.cause != CAUSE_INT_RETURN) || nestedTaskFlag);

   always_comb
   begin
      protRefuse = 1'b0;
      if (cur.viaGate && longMode)
      begin
         protRefuse = 1'b1;
      end
      else if (cur.cause == CAUSE_JUMP || cur.cause == CAUSE_CALL)
      begin
         if (cur.viaGate)
         begin
            // Gate level decides, descriptor level not looked at
            if (cur.gateTable == TABLE_INTERRUPT)
               protRefuse = 1'b1;
            else if (currentPrivilegeLevel > cur.gateLevel || cur.requestedLevel > cur.gateLevel)
               protRefuse = 1'b1;
         end
         else if (cur.gateTable != TABLE_GLOBAL)
         begin
            protRefuse = 1'b1;
         end
         else if (currentPrivilegeLevel > cur.descriptorLevel ||
                  cur.requestedLevel > cur.descriptorLevel)
         begin
            protRefuse = 1'b1;
         end
      end
      // Interrupts and return fall through with no level check
      if (!isReturn && cur.targetBusy)
         protRefuse = 1'b1;
      limitRefuse = !protRefuse && (cur.segLimit < `STATE_SEG_MIN_LIMIT);
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE: if (startReq) next_state = ST_CHECK;
         ST_CHECK: next_state = (protRefuse || limitRefuse) ? ST_IDLE : ST_SAVE;
         // Save fault still belongs to the old task, so it aborts
         ST_SAVE: if (stepFault) next_state = ST_IDLE;
                  else if (stepDone) next_state = ST_TASK_LOAD;
         // From here a fault belongs to the new task, so the sequence runs on
         ST_TASK_LOAD: if (stepDone || stepFault) next_state = ST_BUSY;
         ST_BUSY: if (stepDone || stepFault) next_state = ST_FLAG_SET;
         ST_FLAG_SET: if (stepDone || stepFault) next_state = ST_LOAD;
         ST_LOAD: if (stepDone || stepFault) next_state = ST_MAP_LOAD;
         ST_MAP_LOAD: if (stepDone || stepFault) next_state = ST_DESC_LOAD;
         ST_DESC_LOAD: if (stepDone || stepFault) next_state = ST_DONE;
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cur <= '0;
         oldSel <= '0;
      end
      else if (startReq)
      begin
         cur <= req;
         if (req.cause == CAUSE_INT_RETURN)
            cur.targetSel <= req.linkSel;
         oldSel <= taskRegister;
      end
   end

   // ----------------------------------------------------------------
   // Step commands, registered from the next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_step = '0;
      next_step.targetSel = cur.targetSel;
      next_step.linkSel = oldSel;
      next_step.save = (next_state == ST_SAVE);
      next_step.saveNested = !isReturn && nestedTaskFlag;
      next_step.taskLoad = (next_state == ST_TASK_LOAD);
      next_step.busyUpdate = (next_state == ST_BUSY);
      // Busy lives at bit 9 of byte +4; the mover owns the address
      next_step.oldBusyWrite = next_step.busyUpdate && !callLike;
      next_step.oldBusyValue = 1'b0;
      next_step.newBusyWrite = next_step.busyUpdate && !isReturn;
      next_step.newBusyValue = 1'b1;
      next_step.linkWrite = next_step.busyUpdate && callLike;
      next_step.flagSet = (next_state == ST_FLAG_SET);
      next_step.load = (next_state == ST_LOAD);
      next_step.presentClear = (next_state == ST_LOAD) ||
                               (next_state == ST_MAP_LOAD);
      next_step.mapLoad = (next_state == ST_MAP_LOAD);
      next_step.descLoad = (next_state == ST_DESC_LOAD);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         step <= '0;
      else
         step <= next_step;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         switchActive <= 1'b0;
      else
         switchActive <= (next_state != ST_IDLE);
   end

   // ----------------------------------------------------------------
   // Faults
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         protectionFault <= 1'b0;
      else
         protectionFault <= (state == ST_CHECK) && protRefuse;
   end

   // Late faults are held and delivered only once the new task is loaded
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         pendingLate <= 1'b0;
      else if (stepFault && !(state inside {ST_IDLE, ST_CHECK, ST_SAVE, ST_DONE}))
         pendingLate <= 1'b1;
      else if (state == ST_DONE)
         pendingLate <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         invalidStateFault <= 1'b0;
      else
         invalidStateFault <= ((state == ST_CHECK) && limitRefuse) ||
                              ((state == ST_SAVE) && stepFault) ||
                              ((state == ST_DONE) && pendingLate);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         deviceUnavailableFault <= 1'b0;
      else
         deviceUnavailableFault <= mediaAttempt && taskSwitchedFlag;
   end

   // ----------------------------------------------------------------
   // Architectural state
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         taskRegister <= '0;
      else if (state == ST_TASK_LOAD && (stepDone || stepFault))
         taskRegister <= cur.targetSel;
   end

   // Switch setting wins over a software clear in the same cycle
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         taskSwitchedFlag <= 1'b0;
      else if (state == ST_FLAG_SET && (stepDone || stepFault))
         taskSwitchedFlag <= 1'b1;
      else if (regWr && regAddr == `REG_CONTROL && regWrData[`CTRL_CLEAR_SWITCHED])
         taskSwitchedFlag <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         nestedTaskFlag <= 1'b0;
      else if (state == ST_SAVE && stepDone && isReturn)
         nestedTaskFlag <= 1'b0;
      else if (state == ST_LOAD && (stepDone || stepFault))
         nestedTaskFlag <= callLike ? `NESTED_SET : loadNested;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         currentPrivilegeLevel <= '0;
      else if (state == ST_DONE)
         currentPrivilegeLevel <= codeLevel;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         resume <= 1'b0;
      else
         resume <= (state == ST_DONE);
   end

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         longMode <= 1'b0;
      else if (regWr && regAddr == `REG_CONTROL)
         longMode <= regWrData[`CTRL_LONG_MODE];
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         regRdData <= '0;
      else if (regRd)
      begin
         regRdData <= '0;
         case (regAddr)
            `REG_CONTROL: regRdData[`CTRL_LONG_MODE] <= longMode;
            `REG_STATUS:
            begin
               regRdData[`STAT_LEVEL_LSB +: 2] <= currentPrivilegeLevel;
               regRdData[`STAT_NESTED] <= nestedTaskFlag;
               regRdData[`STAT_SWITCHED] <= taskSwitchedFlag;
               regRdData[`STAT_PENDING] <= pendingLate;
               regRdData[`STAT_ACTIVE] <= switchActive;
            end
            `REG_TASK: regRdData[15:0] <= taskRegister;
            default: regRdData <= '0;
         endcase
      end
      else
         regRdData <= '0;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_gate_long_fault: assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_CHECK && cur.viaGate && longMode) |=> protectionFault && state == ST_IDLE)
      else $error("gate in long mode did not fault");

   a_short_limit: assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_CHECK && !protRefuse && cur.segLimit < `STATE_SEG_MIN_LIMIT)
      |=> invalidStateFault && !step.save)
      else $error("short segment limit not refused");

   a_abort_clean: assert property (@(posedge clock) disable iff (!rst_n)
      protectionFault |-> taskRegister == $past(taskRegister, 2) && !taskSwitchedFlag == !$past(taskSwitchedFlag, 2))
      else $error("aborted switch changed state");

   a_save_then_task: assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_SAVE && stepDone && !stepFault) |=> step.taskLoad && !step.save ##0 !step.busyUpdate)
      else $error("step order broken after save");

   a_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_FLAG_SET && stepDone) |=> taskSwitchedFlag && step.load && step.presentClear)
      else $error("task-switched flag not set");

   a_media_fault: assert property (@(posedge clock) disable iff (!rst_n)
      (mediaAttempt && taskSwitchedFlag) |=> deviceUnavailableFault)
      else $error("media attempt not faulted");

   a_resume_level: assert property (@(posedge clock) disable iff (!rst_n)
      resume |-> currentPrivilegeLevel == $past(codeLevel) && $past(state) == ST_DONE)
      else $error("resume level wrong");

   a_plain_return: assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_IDLE && reqValid && req.cause == CAUSE_INT_RETURN && !nestedTaskFlag)
      |=> (state == ST_IDLE) [*2])
      else $error("plain return started a switch");

   a_jump_busy: assert property (@(posedge clock) disable iff (!rst_n)
      (step.busyUpdate && isJump) |-> step.oldBusyWrite && !step.oldBusyValue && step.newBusyWrite && !step.linkWrite)
      else $error("jump busy update wrong");

   a_call_link: assert property (@(posedge clock) disable iff (!rst_n)
      (step.busyUpdate && callLike) |-> step.linkWrite && step.linkSel == oldSel && !step.oldBusyWrite)
      else $error("call link update wrong");

   a_late_fault: assert property (@(posedge clock) disable iff (!rst_n)
      (state == ST_DESC_LOAD && stepFault) |=> state == ST_DONE ##1 invalidStateFault && resume)
      else $error("late fault not delivered at resume");

endmodule : task_switch_control

`default_nettype wire

// >>> test/hardware_task_switch_control_tb.sv
// Self-checking bench for the task-switch control block
`timescale 1ns/1ns
`default_nettype none
`include "task_switch_params.svh"

module hardware_task_switch_control_tb;
   import task_switch_pkg::*;

   // ------------------------------------------------------------
   // Signals and bookkeeping
   // ------------------------------------------------------------
   typedef struct {logic prot; logic inval; logic rs; logic unavail; logic [15:0] sel; logic [1:0] lev; logic nst;
      logic sw;} note_s;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic reqValid = 1'b0;
   switch_req_s req = '0;
   logic stepDone = 1'b0;
   logic stepFault = 1'b0;
   logic [15:0] loadCodeSel = 16'h0000;
   logic loadNested = 1'b0;
   logic mediaAttempt = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWrData = 32'h00000000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdData;
   step_s step;
   logic protectionFault, invalidStateFault, deviceUnavailableFault, resume, switchActive;
   logic [15:0] taskRegister;
   logic [1:0] currentPrivilegeLevel;
   logic nestedTaskFlag, taskSwitchedFlag, longMode;
   note_s notes[$];
   logic [31:0] rdq[$];
   int failures = 0;
   int nChecks = 0;
   int ord = 0;
   logic [6:0] faultMask = 7'h00;
   logic [6:0] cur, lastCur = 7'h00;
   logic isRet = 1'b0;
   logic isCall = 1'b0;
   logic rdSeen = 1'b0;
   logic lnest = 1'b0;
   logic [1:0] lvl = 2'h2;
   logic [15:0] expTask = 16'h0000;
   logic [15:0] prevTask = 16'h0000;
   logic [1:0] expLevel = 2'h0;
   logic expNested = 1'b0;
   logic prevNested = 1'b0;
   logic expSw = 1'b0;

   always #50 clock = ~clock;

   task_switch_control i_task_switch_control (.clock(clock), .rst_n(rst_n), .reqValid(reqValid), .req(req),
      .stepDone(stepDone), .stepFault(stepFault), .loadCodeSel(loadCodeSel), .loadNested(loadNested),
      .mediaAttempt(mediaAttempt), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .step(step), .protectionFault(protectionFault), .invalidStateFault(invalidStateFault),
      .deviceUnavailableFault(deviceUnavailableFault), .resume(resume), .switchActive(switchActive),
      .taskRegister(taskRegister), .currentPrivilegeLevel(currentPrivilegeLevel), .nestedTaskFlag(nestedTaskFlag),
      .taskSwitchedFlag(taskSwitchedFlag), .longMode(longMode));

   // ------------------------------------------------------------
   // Comparison and reporting
   // ------------------------------------------------------------
   task automatic miss(input string msg);
      failures++;
      $display("MISMATCH at %0t: %s", $time, msg);
   endtask : miss

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", nChecks, failures);
      if (failures == 0 && nChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // ------------------------------------------------------------
   // State mover: answers each step at random pace, checks order
   // ------------------------------------------------------------
   always @(posedge clock)
   begin
      cur = {step.descLoad, step.mapLoad, step.load, step.flagSet, step.busyUpdate, step.taskLoad, step.save};
      // Step outputs are unknown until the first reset edge has passed
      if (rst_n && cur !== 7'h00 && cur !== lastCur)
      begin
         check(cur, 7'h01 << ord);
         ord = ord + 1;
         if (cur[0])
            check(step.saveNested, !isRet && prevNested);
         if (cur[1])
            check(step.targetSel, expTask);
         if (cur[2])
         begin
            check(step.oldBusyWrite && !step.oldBusyValue, !isCall);
            check(step.newBusyWrite && step.newBusyValue, !isRet);
            check(step.newBusyWrite, !isRet);
            check(step.linkWrite, isCall);
            if (isCall)
               check(step.linkSel, prevTask);
         end
         if (cur[4] || cur[5])
            check(step.presentClear, 1'b1);
      end
      lastCur = cur;
      if (rst_n && cur !== 7'h00 && !stepDone && !stepFault && $urandom_range(1, 0) == 1)
      begin
         stepFault <= (cur == faultMask);
         stepDone <= (cur != faultMask);
      end
      else
      begin
         stepFault <= 1'b0;
         stepDone <= 1'b0;
      end
      rdSeen <= regRd;
   end

   // ------------------------------------------------------------
   // Result watcher: takes the oldest note at each result pulse
   // ------------------------------------------------------------
   always @(negedge clock)
   begin
      note_s n;
      if (rdSeen)
         check(regRdData, rdq.pop_front());
      if ((protectionFault | invalidStateFault | resume | deviceUnavailableFault) === 1'b1)
      begin
         if (notes.size() == 0)
            miss("unexpected result pulse");
         else
         begin
            n = notes.pop_front();
            check(protectionFault, n.prot);
            check(invalidStateFault, n.inval);
            check(resume, n.rs);
            check(deviceUnavailableFault, n.unavail);
            check(taskRegister, n.sel);
            check(currentPrivilegeLevel, n.lev);
            check(nestedTaskFlag, n.nst);
            check(taskSwitchedFlag, n.sw);
         end
      end
   end

   // ------------------------------------------------------------
   // Drivers
   // ------------------------------------------------------------
   function automatic switch_req_s mk(input cause_e c, input int g, input table_e t, input int rl, input int gl,
      input int dl, input logic [31:0] lim, input int b);
      return '{c, 1'(g), t, 2'(rl), 2'(gl), 2'(dl), lim, 1'(b), 16'($urandom), 16'($urandom)};
   endfunction : mk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rdq.push_back(e);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      @(posedge clock);
   endtask : rd

   // res: 0 switch, 1 protection fault, 2 invalid state abort, 3 late invalid state with switch
   task automatic run(input string nm, input switch_req_s r, input int res, input logic [6:0] fm = 7'h00,
      input logic dup = 1'b0);
      int k;
      faultMask = fm;
      ord = 0;
      isRet = (r.cause == CAUSE_INT_RETURN);
      isCall = (r.cause inside {CAUSE_CALL, CAUSE_SOFT_INT, CAUSE_EXTERNAL});
      prevTask = expTask;
      prevNested = expNested;
      if (res == 0 || res == 3)
      begin
         expTask = isRet ? r.linkSel : r.targetSel;
         expLevel = lvl;
         expNested = isCall ? 1'b1 : lnest;
         expSw = 1'b1;
      end
      notes.push_back('{res == 1, res >= 2, res == 0 || res == 3, 1'b0, expTask, expLevel, expNested, expSw});
      @(posedge clock);
      reqValid <= 1'b1;
      req <= r;
      loadCodeSel <= {14'($urandom), lvl};
      loadNested <= lnest;
      @(posedge clock);
      reqValid <= 1'b0;
      if (dup)
      begin
         repeat (2) @(posedge clock);
         reqValid <= 1'b1;
         req.targetSel <= ~r.targetSel;
         @(posedge clock);
         reqValid <= 1'b0;
      end
      k = 0;
      while (notes.size() != 0 && k < 80)
      begin
         @(posedge clock);
         k++;
      end
      if (notes.size() != 0)
      begin
         miss("no result for request");
         notes.delete();
      end
      repeat (2) @(posedge clock);
      $display("Test done: %s", nm);
   endtask : run

   task automatic media;
      if (expSw)
         notes.push_back('{1'b0, 1'b0, 1'b0, 1'b1, expTask, expLevel, expNested, expSw});
      @(posedge clock);
      mediaAttempt <= 1'b1;
      @(posedge clock);
      mediaAttempt <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : media

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (5000) @(posedge clock);
      miss("watchdog expired");
      give_verdict();
   end

   initial
   begin
      void'($urandom(97));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rd(`REG_STATUS, 32'h00000000);
      rd(`REG_TASK, 32'h00000000);
      rd(`REG_CONTROL, 32'h00000000);
      rd(4'hF, 32'h00000000);
      lnest = 1'($urandom);
      run("jump gate global, minimum limit", mk(CAUSE_JUMP, 1, TABLE_GLOBAL, 1, 2, 0, 32'h00000067, 0), 0);
      run("jump gate local", mk(CAUSE_JUMP, 1, TABLE_LOCAL, 2, 3, 0, 32'h00000100, 0), 0);
      run("gate rpl above gate level", mk(CAUSE_CALL, 1, TABLE_LOCAL, 3, 2, 3, 32'h00000100, 0), 1);
      run("gate cpl above gate level", mk(CAUSE_JUMP, 1, TABLE_GLOBAL, 0, 1, 3, 32'h00000100, 0), 1);
      run("call direct, level boundary", mk(CAUSE_CALL, 0, TABLE_GLOBAL, 2, 0, 2, 32'h00000200, 0), 0, 7'h00,
         1'b1);
      rd(`REG_STATUS, {26'h0, 2'b00, expSw, expNested, expLevel});
      rd(`REG_TASK, {16'h0000, expTask});
      run("direct from local table", mk(CAUSE_JUMP, 0, TABLE_LOCAL, 0, 0, 3, 32'h00000100, 0), 1);
      run("direct rpl above level", mk(CAUSE_CALL, 0, TABLE_GLOBAL, 3, 3, 2, 32'h00000100, 0), 1);
      run("direct cpl above level", mk(CAUSE_JUMP, 0, TABLE_GLOBAL, 0, 3, 1, 32'h00000100, 0), 1);
      run("soft interrupt skips gate level", mk(CAUSE_SOFT_INT, 1, TABLE_INTERRUPT, 3, 0, 0, 32'h00000100, 0), 0);
      run("external skips gate level", mk(CAUSE_EXTERNAL, 1, TABLE_INTERRUPT, 3, 0, 0, 32'h00000100, 0), 0);
      run("call gate in interrupt table", mk(CAUSE_CALL, 1, TABLE_INTERRUPT, 0, 3, 3, 32'h00000100, 0), 1);
      run("limit one short", mk(CAUSE_JUMP, 1, TABLE_GLOBAL, 0, 3, 3, 32'h00000066, 0), 2);
      run("level fault wins over limit", mk(CAUSE_JUMP, 1, TABLE_GLOBAL, 3, 0, 3, 32'h00000066, 0), 1);
      run("jump to busy task", mk(CAUSE_JUMP, 0, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 1), 1);
      run("call to busy task", mk(CAUSE_CALL, 1, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 1), 1);
      run("fault during save", mk(CAUSE_JUMP, 1, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 0), 2, 7'h01);
      run("fault during load", mk(CAUSE_JUMP, 1, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 0), 3, 7'h10);
      run("fault during descriptors", mk(CAUSE_CALL, 1, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 0), 3, 7'h40);
      run("fault during task load", mk(CAUSE_JUMP, 1, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 0), 3, 7'h02);
      run("call before return", mk(CAUSE_CALL, 1, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 0), 0);
      lnest = 1'b0;
      run("return to link, busy target", mk(CAUSE_INT_RETURN, 0, TABLE_GLOBAL, 3, 0, 0, 32'h00000067, 1), 0);
      @(posedge clock);
      reqValid <= 1'b1;
      req <= mk(CAUSE_INT_RETURN, 0, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 0);
      @(posedge clock);
      reqValid <= 1'b0;
      repeat (6)
      begin
         @(negedge clock);
         check(switchActive, 1'b0);
      end
      $display("Test done: return without nesting");
      wr(`REG_CONTROL, 32'h00000001);
      @(negedge clock);
      check(longMode, 1'b1);
      run("long mode gate global", mk(CAUSE_JUMP, 1, TABLE_GLOBAL, 0, 3, 3, 32'h00000100, 0), 1);
      run("long mode gate interrupt", mk(CAUSE_EXTERNAL, 1, TABLE_INTERRUPT, 0, 3, 3, 32'h00000100, 0), 1);
      wr(`REG_CONTROL, 32'h00000000);
      media();
      wr(`REG_CONTROL, 32'h00000002);
      expSw = 1'b0;
      media();
      rd(`REG_STATUS, {26'h0, 2'b00, expSw, expNested, expLevel});
      $display("Test done: media and register port");
      repeat (4) @(posedge clock);
      give_verdict();
   end

endmodule : hardware_task_switch_control_tb
`default_nettype wire
